// [common/slm_pkg.sv]
package slm_pkg;

    // Register bus geometry
    localparam int          ADDR_W          = 2;
    localparam int          DATA_W          = 8;
    localparam logic [1:0]  ADDR_CTRL       = 2'h0;
    localparam logic [1:0]  ADDR_STAT       = 2'h1;

    // Control register fields
    localparam int          CTRL_RANGE_BIT  = 3;
    localparam int          CTRL_TRIM_LSB   = 0;
    localparam int          TRIM_W          = 3;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Status register fields
    localparam int          STAT_RESULT_BIT = 2;
    localparam int          STAT_VALID_BIT  = 1;
    localparam int          STAT_EN_BIT     = 0;
    localparam logic [7:0]  STAT_RESET      = 8'h00;

    // Interrupt manager mapping
    localparam int          IRQ_GRP_W       = 8;
    localparam int          IRQ_MID_BIT     = 2;

    // Timing
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          MEAS_TIME_NS    = 2000000;
    localparam int          MEAS_MAX_NS     = 2500000;
    localparam int          MIN_PULSE_NS    = 1350000;
    localparam int          MEAS_CYCLES     = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          MEAS_MAX_CYCLES = MEAS_MAX_NS / CLK_PERIOD_NS;
    localparam int          PULSE_CYCLES    = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 20;

    typedef enum logic [1:0] {
        SLM_OFF,
        SLM_SETTLE,
        SLM_RUN
    } slm_state_e;

endpackage

// [rtl/slm_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module slm_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Pin side
    input  wire logic async_in,
    // Clock domain side
    output logic      stable_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } slm_sync_s;

    slm_sync_s st;
    slm_sync_s next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A new level counts only once the last two stages agree
        if (st.s2 == st.s3) begin
            next_st.out = st.s3;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stable_out = st.out;

endmodule

`default_nettype wire

// [rtl/slm_ctrl.sv]
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module slm_ctrl #(
    parameter int SETTLE_CYCLES = slm_pkg::MEAS_CYCLES,
    parameter int MAX_CYCLES    = slm_pkg::MEAS_MAX_CYCLES,
    parameter int DIP_CYCLES    = slm_pkg::PULSE_CYCLES,
    parameter int CNT_W         = slm_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              reset,
    // Register port
    input  wire logic [slm_pkg::ADDR_W-1:0]        reg_addr,
    input  wire logic [slm_pkg::DATA_W-1:0]        reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [slm_pkg::DATA_W-1:0]        reg_rdata,
    // Analog detector
    input  wire logic                              cmp_below,
    output logic                                   det_power_on,
    output logic                                   threshold_range_sel,
    output logic      [slm_pkg::TRIM_W-1:0]        threshold_trim,
    // Interrupt manager
    output logic                                   low_voltage_irq,
    output logic      [slm_pkg::IRQ_GRP_W-1:0]     irq_mid_group_reg
);

    import slm_pkg::*;

    typedef struct packed {
        slm_state_e               fsm;
        logic [CNT_W-1:0]         cnt;
        logic                     detector_enable_bit;
        logic                     range_sel;
        logic [TRIM_W-1:0]        trim;
        logic                     measure_valid_flag;
        logic                     battery_low_flag;
        logic                     irq;
        logic [IRQ_GRP_W-1:0]     irq_mid;
        logic [DATA_W-1:0]        rdata;
    } slm_ctrl_s;

    slm_ctrl_s st;
    slm_ctrl_s next_st;
    logic      below_s;

    function automatic logic hits(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] target);
        hits = (a == target);
    endfunction

    // Comparator output is asynchronous to the system clock
    slm_sync u_sync (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .async_in   (cmp_below),
        .stable_out (below_s)
    );

    always_comb begin
        next_st = st;

        // Register writes
        if (reg_wr && hits(reg_addr, ADDR_CTRL)) begin
            next_st.range_sel = reg_wdata[CTRL_RANGE_BIT];
            next_st.trim      = reg_wdata[CTRL_TRIM_LSB +: TRIM_W];
        end
        if (reg_wr && hits(reg_addr, ADDR_STAT)) begin
            next_st.detector_enable_bit = reg_wdata[STAT_EN_BIT];
        end

        // Measurement sequencing
        unique case (st.fsm)
            SLM_OFF: begin
                next_st.measure_valid_flag = 1'b0;
                if (next_st.detector_enable_bit) begin
                    next_st.fsm = SLM_SETTLE;
                    next_st.cnt = '0;
                end
            end
            SLM_SETTLE: begin
                if (!next_st.detector_enable_bit) begin
                    next_st.fsm = SLM_OFF;
                end else if (st.cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
                    next_st.fsm                = SLM_RUN;
                    next_st.measure_valid_flag = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
            SLM_RUN: begin
                if (!next_st.detector_enable_bit) begin
                    next_st.fsm                = SLM_OFF;
                    next_st.measure_valid_flag = 1'b0;
                end
            end
        endcase

        // Comparator is powered only while enabled
        next_st.battery_low_flag = below_s && next_st.detector_enable_bit;

        // Pulse on each rising edge once the result is trustworthy
        next_st.irq = next_st.battery_low_flag && !st.battery_low_flag
                      && st.measure_valid_flag && next_st.detector_enable_bit;
        next_st.irq_mid              = '0;
        next_st.irq_mid[IRQ_MID_BIT] = next_st.irq;

        // Read data stands for one cycle only
        next_st.rdata = '0;
        if (reg_rd && hits(reg_addr, ADDR_CTRL)) begin
            next_st.rdata[CTRL_RANGE_BIT]              = st.range_sel;
            next_st.rdata[CTRL_TRIM_LSB +: TRIM_W]     = st.trim;
        end
        if (reg_rd && hits(reg_addr, ADDR_STAT)) begin
            next_st.rdata[STAT_RESULT_BIT] = st.battery_low_flag;
            next_st.rdata[STAT_VALID_BIT]  = st.measure_valid_flag;
            next_st.rdata[STAT_EN_BIT]     = st.detector_enable_bit;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st           <= '0;
            st.fsm       <= SLM_OFF;
            st.range_sel <= CTRL_RESET[CTRL_RANGE_BIT];
            st.trim      <= CTRL_RESET[CTRL_TRIM_LSB +: TRIM_W];
            st.detector_enable_bit <= STAT_RESET[STAT_EN_BIT];
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata           = st.rdata;
    assign det_power_on        = st.detector_enable_bit;
    assign threshold_range_sel = st.range_sel;
    assign threshold_trim      = st.trim;
    assign low_voltage_irq     = st.irq;
    assign irq_mid_group_reg   = st.irq_mid;

    // ------------------------------------------------------------------
    // Checking helpers
    logic [CNT_W-1:0] en_age;
    logic [CNT_W-1:0] dip_age;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            en_age <= '0;
        end else if (!next_st.detector_enable_bit) begin
            en_age <= '0;
        end else if (st.detector_enable_bit && (en_age != '1)) begin
            en_age <= en_age + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dip_age <= '0;
        end else if (!(below_s && st.measure_valid_flag)) begin
            dip_age <= '0;
        end else if (dip_age != '1) begin
            dip_age <= dip_age + 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (reset);

    sequence s_enable_rise;
        !st.detector_enable_bit ##1 st.detector_enable_bit;
    endsequence

    sequence s_low_rise_valid;
        (st.measure_valid_flag && !st.battery_low_flag) ##1 st.battery_low_flag;
    endsequence

    sequence s_stat_read;
        reg_rd && hits(reg_addr, ADDR_STAT);
    endsequence

    sequence s_ctrl_read;
        reg_rd && hits(reg_addr, ADDR_CTRL);
    endsequence

    // Low flag follows the synchronised comparator while enabled
    a_low_flag_level: assert property (
        st.battery_low_flag == ($past(below_s) && st.detector_enable_bit))
        else $error("low-supply flag does not follow comparator");

    a_low_flag_read: assert property (
        s_stat_read |=> reg_rdata[STAT_RESULT_BIT] == $past(st.battery_low_flag))
        else $error("status read shows wrong low-supply flag");

    // Valid only in the running state with the detector on
    a_valid_running: assert property (
        st.measure_valid_flag |-> (st.fsm == SLM_RUN) && st.detector_enable_bit)
        else $error("valid flag set outside a running measurement");

    a_valid_read: assert property (
        s_stat_read |=> reg_rdata[STAT_VALID_BIT] == $past(st.measure_valid_flag))
        else $error("status read shows wrong valid flag");

    // Enable bit takes the written value and reads back
    a_enable_write: assert property (
        reg_wr && hits(reg_addr, ADDR_STAT)
        |=> st.detector_enable_bit == $past(reg_wdata[STAT_EN_BIT])
            && det_power_on == $past(reg_wdata[STAT_EN_BIT]))
        else $error("enable bit did not take written value");

    a_status_reserved: assert property (
        s_stat_read |=> reg_rdata[DATA_W-1:STAT_RESULT_BIT+1] == '0
                        && reg_rdata[STAT_EN_BIT] == $past(st.detector_enable_bit))
        else $error("status read shows wrong enable or reserved bits");

    // Interrupt appears only on its group position
    a_irq_mapping: assert property (
        irq_mid_group_reg == (IRQ_GRP_W'(low_voltage_irq) << IRQ_MID_BIT))
        else $error("interrupt not on its group bit");

    // Threshold controls follow control writes
    a_threshold_ctrl: assert property (
        reg_wr && hits(reg_addr, ADDR_CTRL)
        |=> threshold_trim == $past(reg_wdata[CTRL_TRIM_LSB +: TRIM_W])
            && threshold_range_sel == $past(reg_wdata[CTRL_RANGE_BIT]))
        else $error("threshold controls did not follow write");

    // Enable rise begins a fresh settle
    a_start_measure: assert property (
        s_enable_rise |-> st.fsm == SLM_SETTLE && st.cnt == '0
                          && !st.measure_valid_flag)
        else $error("measurement did not start on enable");

    // Valid rises exactly the settle time after enable
    a_valid_delay: assert property (
        $rose(st.measure_valid_flag) |-> en_age == CNT_W'(SETTLE_CYCLES))
        else $error("valid flag rose at wrong time");

    a_valid_holds: assert property (
        st.measure_valid_flag && st.detector_enable_bit
        ##1 st.detector_enable_bit |-> st.measure_valid_flag)
        else $error("valid flag dropped while enabled");

    // A new low edge under valid raises the interrupt
    a_irq_on_dip: assert property (
        s_low_rise_valid ##0 st.detector_enable_bit |-> low_voltage_irq)
        else $error("low-supply edge gave no interrupt");

    a_irq_needs_valid: assert property (
        low_voltage_irq |-> $past(st.measure_valid_flag) && st.detector_enable_bit)
        else $error("interrupt raised while not valid or disabled");

    // One pulse per rising edge, none while high
    a_irq_single: assert property (
        low_voltage_irq |-> $rose(st.battery_low_flag) ##1 !low_voltage_irq)
        else $error("interrupt not a single pulse on an edge");

    a_irq_quiet_high: assert property (
        st.battery_low_flag [*2] |-> !low_voltage_irq)
        else $error("interrupt repeated while flag stays high");

    // Measurement completes within the longest time
    a_measure_bound: assert property (
        st.detector_enable_bit && en_age >= CNT_W'(MAX_CYCLES)
        |-> st.measure_valid_flag)
        else $error("measurement exceeded longest duration");

    // A dip held for the shortest pulse width is seen
    a_dip_seen: assert property (
        dip_age >= CNT_W'(DIP_CYCLES) && st.detector_enable_bit
        |-> st.battery_low_flag)
        else $error("sustained dip not reported");

    // Control layout reads back with reserved bits low
    a_ctrl_read: assert property (
        s_ctrl_read |=> reg_rdata == {4'h0, $past(st.range_sel), $past(st.trim)})
        else $error("control read back mismatch");

    // Disable clears valid and stops measuring
    a_disable_clears: assert property (
        $fell(st.detector_enable_bit)
        |-> !st.measure_valid_flag && st.fsm == SLM_OFF && !st.battery_low_flag)
        else $error("disable did not clear valid and result");

    a_off_idle: assert property (
        !st.detector_enable_bit |-> !st.measure_valid_flag && !low_voltage_irq)
        else $error("flags active while disabled");

    // Read data stands for one cycle only
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data present without a read");

endmodule

`default_nettype wire

// [bench/slm_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module slm_ctrl_tb_top;
    import slm_pkg::*;

    localparam int SETTLE = 20;
    localparam int MAXC   = 25;
    localparam int DIP    = 10;

    logic                 sys_clk;
    logic                 reset;
    logic [ADDR_W-1:0]    reg_addr;
    logic [DATA_W-1:0]    reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [DATA_W-1:0]    reg_rdata;
    logic                 cmp_below;
    logic                 det_power_on;
    logic                 threshold_range_sel;
    logic [TRIM_W-1:0]    threshold_trim;
    logic                 low_voltage_irq;
    logic [IRQ_GRP_W-1:0] irq_mid_group_reg;
    int                   err_count;
    int                   compares;
    int                   irq_count;
    logic [7:0]           rdv;

    slm_ctrl #(
        .SETTLE_CYCLES (SETTLE),
        .MAX_CYCLES    (MAXC),
        .DIP_CYCLES    (DIP),
        .CNT_W         (CNT_W)
    ) dut (
        .sys_clk             (sys_clk),
        .reset               (reset),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .cmp_below           (cmp_below),
        .det_power_on        (det_power_on),
        .threshold_range_sel (threshold_range_sel),
        .threshold_trim      (threshold_trim),
        .low_voltage_irq     (low_voltage_irq),
        .irq_mid_group_reg   (irq_mid_group_reg)
    );

    always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Irq pulses are counted mid-cycle, away from the launching edge
    always @(negedge sys_clk) begin
        if (low_voltage_irq === 1'b1) begin
            irq_count++;
        end
        chk(irq_mid_group_reg & 8'hfb, 8'h00);
    end

    task automatic conclude();
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_cmp(input logic v, input int n);
        @(posedge sys_clk);
        cmp_below <= v;
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic t_reset_values();
        rd(ADDR_CTRL, rdv);
        chk(rdv, CTRL_RESET);
        rd(ADDR_STAT, rdv);
        chk(rdv, STAT_RESET);
        chk({6'h00, det_power_on, threshold_range_sel}, 8'h00);
    endtask

    task automatic t_control();
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_CTRL, {4'hf, i[3:0]});
            chk({4'h0, threshold_range_sel, threshold_trim}, {4'h0, i[3:0]});
            rd(ADDR_CTRL, rdv);
            chk(rdv, {4'h0, i[3:0]});
        end
        wr(2'h2, 8'hff);
        wr(2'h3, 8'hff);
        rd(2'h2, rdv);
        chk(rdv, 8'h00);
        rd(2'h3, rdv);
        chk(rdv, 8'h00);
        rd(ADDR_CTRL, rdv);
        chk(rdv, 8'h0f);
    endtask

    task automatic t_enable();
        wr(ADDR_STAT, 8'hff);
        chk({7'h00, det_power_on}, 8'h01);
        repeat (SETTLE - 5) @(posedge sys_clk);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h01);
        repeat (3) @(posedge sys_clk);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h03);
        wr(ADDR_STAT, 8'h01);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h03);
    endtask

    task automatic t_low_flag();
        int base;
        int n;
        base = irq_count;
        @(posedge sys_clk);
        cmp_below <= 1'b1;
        n = 0;
        while (low_voltage_irq !== 1'b1 && n < 12) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk({7'h00, low_voltage_irq}, 8'h01);
        chk(irq_mid_group_reg, 8'h04);
        if (n >= 12) begin
            conclude();
        end
        repeat (30) @(posedge sys_clk);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h07);
        chk(irq_count[7:0], base[7:0] + 8'h01);
        wait_cmp(1'b0, 10);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h03);
        wait_cmp(1'b1, DIP);
        wait_cmp(1'b0, 12);
        chk(irq_count[7:0], base[7:0] + 8'h02);
    endtask

    task automatic t_disable();
        int base;
        base = irq_count;
        wr(ADDR_STAT, 8'h00);
        chk({7'h00, det_power_on}, 8'h00);
        wait_cmp(1'b1, 10);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h00);
        wr(ADDR_STAT, 8'h01);
        repeat (SETTLE + 5) @(posedge sys_clk);
        rd(ADDR_STAT, rdv);
        chk(rdv, 8'h07);
        chk(irq_count[7:0], base[7:0]);
    endtask

    task automatic t_mid_reset();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset     <= 1'b0;
        cmp_below <= 1'b0;
        #1;
        chk({6'h00, det_power_on, threshold_range_sel}, 8'h00);
        chk({5'h00, threshold_trim}, 8'h00);
        rd(ADDR_STAT, rdv);
        chk(rdv, STAT_RESET);
        rd(ADDR_CTRL, rdv);
        chk(rdv, CTRL_RESET);
    endtask

    initial begin
        sys_clk   = 1'b0;
        reset     = 1'b1;
        reg_addr  = 2'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        cmp_below = 1'b0;
        err_count = 0;
        compares  = 0;
        irq_count = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_values();
        t_control();
        t_enable();
        t_low_flag();
        t_disable();
        t_mid_reset();
        conclude();
    end
endmodule

`default_nettype wire
